// ### hdl/eeprom_spi_pkg.sv
// Constants shared by the serial EEPROM front end.
// Assumes a 10 MHz core clock and an SPI master that drives the link clock.
package eeprom_spi_pkg;

  // Opcode decode, bit 3 is a don't-care
  localparam logic [7:0] OPC_MASK = 8'hF7;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;

  // Status byte layout
  localparam int ST_PROTECT_PIN_EN = 7;
  localparam int ST_BLOCK_HI = 3;
  localparam int ST_BLOCK_LO = 2;
  localparam int ST_WRITE_LATCH = 1;
  localparam int ST_READY_BUSY = 0;
  localparam logic [2:0] RFU_BUSY = 3'h7;
  localparam logic [2:0] RFU_IDLE = 3'h0;

  // Shipped condition of array and nonvolatile bits
  localparam logic [7:0] SHIPPED_FILL = 8'hFF;
  localparam logic [2:0] SHIPPED_NV_BITS = 3'h0;

  // Framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int ADDR_BYTES = 3;

  // Self-timed write cycle, longest time rounds down
  localparam longint CLK_HZ = 10_000_000;
  localparam longint WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_CYC = int'((WRITE_CYCLE_MS * CLK_HZ) / 1000);

  typedef enum logic [2:0] {
    LS_OPCODE,
    LS_STAT_WR,
    LS_STAT_RD,
    LS_ADDR_RD,
    LS_ADDR_WR,
    LS_ARRAY_RD,
    LS_SINK,
    LS_IGNORE
  } link_state_e;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_WRITE_ENABLE_CMD,
    CMD_WRITE_DISABLE_CMD,
    CMD_STATUS_WRITE_CMD
  } cmd_e;

endpackage : eeprom_spi_pkg

// ### hdl/eeprom_spi_front.sv
// SPI slave front end of a serial EEPROM: link logic on sck_i, status and
// write-cycle logic on clk_i. Assumes the master keeps modes 0 or 3 and
// that the nonvolatile bit store presents its contents on nv_init_i.
module eeprom_spi_front
  import eeprom_spi_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLE_CYC
) (
  // Core clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // SPI link
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Control pins
  input wire logic hold_b_i,
  input wire logic wp_b_i,
  // Nonvolatile bit store
  input wire logic [2:0] nv_init_i,
  output logic nv_wr_o,
  output logic [2:0] nv_bits_o,
  // Status view
  output logic [7:0] status_o
);

  // Write-cycle timer width and end points
  localparam int TW = $clog2(WRITE_CYC + 1);
  localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYC - 1);
  localparam logic [TW-1:0] TIMER_ZERO = '0;
  localparam logic [1:0] ADDR_LAST = 2'(ADDR_BYTES - 1);

  typedef struct packed {
    logic [2:0] cs_sync;
    logic cs_prev;
    logic [1:0] tgl_sync;
    logic tgl_prev;
    logic [1:0] wp_sync;
    logic wp_prev;
    logic [1:0] hold_sync;
    logic armed;
    logic nv_loaded;
    logic protect_pin_enable;
    logic block_protect_hi;
    logic block_protect_lo;
    logic write_latch_flag;
    logic ready_busy_flag;
    logic [TW-1:0] timer;
    cmd_e pend;
    logic [7:0] pend_data;
    logic nv_wr;
    logic wp_cut;
  } core_s;

  typedef struct packed {
    link_state_e state;
    logic [2:0] bitcnt;
    logic [6:0] sh;
    logic [1:0] bytecnt;
    logic [7:0] tx;
  } rx_s;

  typedef struct packed {
    logic tgl;
    cmd_e kind;
    logic [7:0] data;
  } xfer_s;

  typedef struct packed {
    logic so;
    logic oe;
    logic hold_lat;
  } tx_s;

  localparam core_s CORE_RST = '{
    cs_sync: 3'h7, cs_prev: 1'b1, tgl_sync: 2'h0, tgl_prev: 1'b0,
    wp_sync: 2'h3, wp_prev: 1'b1, hold_sync: 2'h3, armed: 1'b0,
    nv_loaded: 1'b0, protect_pin_enable: 1'b0, block_protect_hi: 1'b0,
    block_protect_lo: 1'b0, write_latch_flag: 1'b0, ready_busy_flag: 1'b0,
    timer: '0, pend: CMD_NONE, pend_data: 8'h00, nv_wr: 1'b0, wp_cut: 1'b0};
  localparam rx_s RX_RST = '{
    state: LS_OPCODE, bitcnt: BIT_FIRST, sh: 7'h00, bytecnt: 2'h0, tx: 8'h00};
  localparam xfer_s XFER_RST = '{tgl: 1'b0, kind: CMD_NONE, data: 8'h00};
  localparam tx_s TX_RST = '{so: 1'b0, oe: 1'b0, hold_lat: 1'b0};

  // Reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_n;

  core_s core_q;
  core_s core_d;
  rx_s rx_q;
  rx_s rx_d;
  xfer_s xfer_q;
  xfer_s xfer_d;
  tx_s tx_q;
  tx_s tx_d;

  logic link_rst_n;
  logic [7:0] status_byte;
  logic held;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Status byte seen by both domains
  // Link reads it without synchronising, once per byte
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_PROTECT_PIN_EN] = core_q.protect_pin_enable;
    status_byte[6:4] = core_q.ready_busy_flag ? RFU_BUSY : RFU_IDLE;
    status_byte[ST_BLOCK_HI] = core_q.block_protect_hi;
    status_byte[ST_BLOCK_LO] = core_q.block_protect_lo;
    status_byte[ST_WRITE_LATCH] = core_q.write_latch_flag;
    status_byte[ST_READY_BUSY] = core_q.ready_busy_flag;
  end

  // ---------------- Core domain ----------------
  always_comb begin
    logic cs_hi;
    logic cs_rise;
    logic tgl_evt;
    logic wp_low;
    logic wp_fall;
    logic hold_on;
    logic refused;
    cs_hi = 1'b1;
    cs_rise = 1'b0;
    tgl_evt = 1'b0;
    wp_low = 1'b0;
    wp_fall = 1'b0;
    hold_on = 1'b0;
    refused = 1'b0;
    core_d = core_q;
    core_d.nv_wr = 1'b0;
    // Two-flop synchronisers; chip-select gets a third stage
    core_d.cs_sync = {core_q.cs_sync[1:0], cs_b_i};
    core_d.tgl_sync = {core_q.tgl_sync[0], xfer_q.tgl};
    core_d.wp_sync = {core_q.wp_sync[0], wp_b_i};
    core_d.hold_sync = {core_q.hold_sync[0], hold_b_i};
    cs_hi = core_q.cs_sync[2];
    cs_rise = cs_hi && !core_q.cs_prev;
    core_d.cs_prev = cs_hi;
    tgl_evt = core_q.tgl_sync[1] ^ core_q.tgl_prev;
    core_d.tgl_prev = core_q.tgl_sync[1];
    wp_low = !core_q.wp_sync[1];
    wp_fall = core_q.wp_prev && wp_low;
    core_d.wp_prev = core_q.wp_sync[1];
    hold_on = !core_q.hold_sync[1];
    // Strap the stored protect bits once after reset release
    if (!core_q.nv_loaded) begin
      core_d.nv_loaded = 1'b1;
      core_d.protect_pin_enable = nv_init_i[2];
      core_d.block_protect_hi = nv_init_i[1];
      core_d.block_protect_lo = nv_init_i[0];
    end
    // Link arms at the first core edge after reset, as cs_sync resets to deselect
    if (cs_hi) begin
      core_d.armed = 1'b1;
    end
    // Toggle is seen two flops late; kind and data are long settled
    if (tgl_evt) begin
      core_d.pend = xfer_q.kind;
      core_d.pend_data = xfer_q.data;
    end
    // Self-timed cycle runs regardless of hold or protect pin
    // Ahead of command handling so a latch set in the same cycle wins
    if (core_q.ready_busy_flag) begin
      if (core_q.timer == TIMER_ZERO) begin
        core_d.ready_busy_flag = 1'b0;
        core_d.write_latch_flag = 1'b0;
      end else begin
        core_d.timer = core_q.timer - 1'b1;
      end
    end
    // Protect pin falling mid-frame is kept until deselect, so a pin
    // that drops and recovers in the frame still cancels the status write
    if (wp_fall && !cs_hi && core_q.protect_pin_enable) begin
      core_d.wp_cut = 1'b1;
      if (core_q.pend == CMD_STATUS_WRITE_CMD) begin
        core_d.pend = CMD_NONE;
      end
    end
    refused = (wp_low && core_q.protect_pin_enable) || core_q.wp_cut;
    // Commands act on deselect, as seen through the synchroniser
    if (cs_rise) begin
      core_d.pend = CMD_NONE;
      core_d.wp_cut = 1'b0;
      if (hold_on) begin
        core_d.write_latch_flag = 1'b0;
      end else begin
        case (core_q.pend)
          CMD_WRITE_ENABLE_CMD: begin
            core_d.write_latch_flag = 1'b1;
          end
          CMD_WRITE_DISABLE_CMD: begin
            core_d.write_latch_flag = 1'b0;
          end
          CMD_STATUS_WRITE_CMD: begin
            if (core_q.write_latch_flag && !refused && !core_q.ready_busy_flag) begin
              core_d.protect_pin_enable = core_q.pend_data[ST_PROTECT_PIN_EN];
              core_d.block_protect_hi = core_q.pend_data[ST_BLOCK_HI];
              core_d.block_protect_lo = core_q.pend_data[ST_BLOCK_LO];
              core_d.ready_busy_flag = 1'b1;
              core_d.timer = TIMER_LOAD;
              core_d.nv_wr = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  // ---------------- Link domain ----------------
  // Deselect or an unarmed core holds the link in reset
  assign link_rst_n = !cs_b_i && core_q.armed;

  always_comb begin
    logic [7:0] rx_byte;
    logic [7:0] op;
    rx_byte = {rx_q.sh, si_i};
    op = rx_byte & OPC_MASK;
    rx_d = rx_q;
    xfer_d = xfer_q;
    // Bit counter and shifter advance only while not held
    if (hold_b_i) begin
      rx_d.bitcnt = rx_q.bitcnt + 1'b1;
      rx_d.sh = {rx_q.sh[5:0], si_i};
      if (rx_q.bitcnt == BIT_LAST) begin
        case (rx_q.state)
          LS_OPCODE: begin
            if (status_byte[ST_READY_BUSY] && op != OPC_STATUS_READ) begin
              rx_d.state = LS_IGNORE;
            end else if (op == OPC_WRITE_ENABLE) begin
              rx_d.state = LS_SINK;
              xfer_d.kind = CMD_WRITE_ENABLE_CMD;
              xfer_d.tgl = !xfer_q.tgl;
            end else if (op == OPC_WRITE_DISABLE) begin
              rx_d.state = LS_SINK;
              xfer_d.kind = CMD_WRITE_DISABLE_CMD;
              xfer_d.tgl = !xfer_q.tgl;
            end else if (op == OPC_STATUS_READ) begin
              rx_d.state = LS_STAT_RD;
              rx_d.tx = status_byte;
            end else if (op == OPC_STATUS_WRITE) begin
              rx_d.state = LS_STAT_WR;
            end else if (op == OPC_ARRAY_READ) begin
              rx_d.state = LS_ADDR_RD;
              rx_d.bytecnt = 2'h0;
            end else if (op == OPC_ARRAY_WRITE) begin
              rx_d.state = LS_ADDR_WR;
              rx_d.bytecnt = 2'h0;
            end else begin
              rx_d.state = LS_IGNORE;
            end
          end
          LS_STAT_WR: begin
            rx_d.state = LS_SINK;
            xfer_d.kind = CMD_STATUS_WRITE_CMD;
            xfer_d.data = rx_byte;
            xfer_d.tgl = !xfer_q.tgl;
          end
          LS_STAT_RD: begin
            rx_d.tx = status_byte;
          end
          LS_ADDR_RD, LS_ADDR_WR: begin
            rx_d.bytecnt = rx_q.bytecnt + 1'b1;
            if (rx_q.bytecnt == ADDR_LAST) begin
              rx_d.state = (rx_q.state == LS_ADDR_RD) ? LS_ARRAY_RD : LS_SINK;
              rx_d.tx = SHIPPED_FILL;
            end
          end
          LS_ARRAY_RD: begin
            rx_d.tx = SHIPPED_FILL;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Capture on rising clock whatever the idle level
  always_ff @(posedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_q <= RX_RST;
    end else begin
      rx_q <= rx_d;
    end
  end

  // Command handoff survives deselect
  always_ff @(posedge sck_i or negedge rst_n) begin
    if (!rst_n) begin
      xfer_q <= XFER_RST;
    end else begin
      xfer_q <= xfer_d;
    end
  end

  always_comb begin
    // Output enable and bit select for the next falling clock
    tx_d = tx_q;
    tx_d.hold_lat = !hold_b_i;
    if (hold_b_i) begin
      tx_d.oe = (rx_q.state == LS_STAT_RD) || (rx_q.state == LS_ARRAY_RD);
      tx_d.so = rx_q.tx[~rx_q.bitcnt];
    end
  end

  // Drive on falling clock
  always_ff @(negedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_q <= TX_RST;
    end else begin
      tx_q <= tx_d;
    end
  end

  // Hold acts at once in the low phase, else from the last falling edge
  assign held = sck_i ? tx_q.hold_lat : !hold_b_i;

  assign so_o = tx_q.so;
  assign so_oe_o = !cs_b_i && tx_q.oe && !held;
  assign nv_wr_o = core_q.nv_wr;
  assign nv_bits_o = {core_q.protect_pin_enable, core_q.block_protect_hi,
                      core_q.block_protect_lo};
  assign status_o = status_byte;

endmodule : eeprom_spi_front

// ### dv/eeprom_spi_front_checker.sv
// Assertions on the EEPROM SPI front end ports.
// Assumes a bind to eeprom_spi_front.
module eeprom_spi_front_checker
  import eeprom_spi_pkg::*;
#(
  parameter int WRITE_CYC = 20
) (
  // Core
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  // Pins
  input wire logic hold_b_i,
  input wire logic wp_b_i,
  // Store and status
  input wire logic [2:0] nv_init_i,
  input wire logic nv_wr_o,
  input wire logic [2:0] nv_bits_o,
  input wire logic [7:0] status_o
);
  int cnt_q;
  logic [2:0] up_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 0;
      up_q <= 3'h0;
    end else begin
      cnt_q <= status_o[0] ? cnt_q + 1 : 0;
      if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_off_desel; cs_b_i |-> !so_oe_o; endproperty
  a_off_desel: assert property (p_off_desel) else $error("so on while deselected");
  property p_hold_off; (!hold_b_i && !sck_i) |-> !so_oe_o; endproperty
  a_hold_off: assert property (p_hold_off) else $error("so on while held");
  property p_start; nv_wr_o |-> status_o[0] && status_o[6:4] == RFU_BUSY; endproperty
  a_start: assert property (p_start) else $error("commit without busy");
  property p_nv_copy; nv_wr_o |-> nv_bits_o == {status_o[7], status_o[3:2]}; endproperty
  a_nv_copy: assert property (p_nv_copy) else $error("store bits differ");
  property p_busy_cause; $rose(status_o[0]) |-> nv_wr_o; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without commit");
  property p_busy_len;
    $fell(status_o[0]) |-> cnt_q >= WRITE_CYC && cnt_q <= WRITE_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length");
  property p_end; $fell(status_o[0]) |-> !status_o[1] && status_o[6:4] == RFU_IDLE; endproperty
  a_end: assert property (p_end) else $error("latch kept after cycle");
  property p_rfu; !status_o[0] |-> status_o[6:4] == RFU_IDLE; endproperty
  a_rfu: assert property (p_rfu) else $error("reserved bits set when idle");
  property p_nv_hold;
    (up_q == 3'h7 && $changed({status_o[7], status_o[3:2]})) |-> nv_wr_o;
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("stored bits changed");
  property p_latch_cs; $rose(status_o[1]) |-> cs_b_i; endproperty
  a_latch_cs: assert property (p_latch_cs) else $error("latch set while selected");
endmodule : eeprom_spi_front_checker

// ### dv/spi_master_model.sv
// SPI master stand-in, mode 0 or 3, 32 ns link clock only within frames.
// Assumes the bench calls one task at a time.
module spi_master_model (
  // Link
  input wire logic so_i,
  output logic sck_o,
  output logic cs_b_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic frame(input logic m3, input logic [39:0] tx, input int nb,
                       output logic [7:0] rx);
    sck_o = m3;
    #16 cs_b_o = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      #16 sck_o = 1'b0;
      si_o = tx[39-i];
      #16 sck_o = 1'b1;
      rx = {rx[6:0], so_i};
    end
    #16 sck_o = m3;
    si_o = ~si_o;
    #16 cs_b_o = 1'b1;
    #800;
  endtask : frame
  task automatic cs_pulse();
    #16 cs_b_o = 1'b0;
    #200 cs_b_o = 1'b1;
    #800;
  endtask : cs_pulse
endmodule : spi_master_model

// ### dv/tb_serial_eeprom_spi_front_end.sv
// Self-checking bench for the EEPROM SPI front end.
// Assumes the SPI master model drives the link.
module tb_serial_eeprom_spi_front_end
  import eeprom_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WRITE_CYC = 40;
  logic clk_i, rst_b_i, sck_i, cs_b_i, si_i, so_o, so_oe_o, hold_b_i, wp_b_i, nv_wr_o, so_w;
  logic [2:0] nv_init_i, nv_bits_o, nv;
  logic [7:0] status_o, rx;
  logic [31:0] r;
  int seed, mismatches, check_count;
  // Released line reads back the inverse of the last bit
  assign so_w = so_oe_o ? so_o : ~so_o;
  always #50 clk_i = ~clk_i;
  eeprom_spi_front #(.WRITE_CYC(WRITE_CYC)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sck_i(sck_i), .cs_b_i(cs_b_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .hold_b_i(hold_b_i), .wp_b_i(wp_b_i), .nv_init_i(nv_init_i), .nv_wr_o(nv_wr_o),
    .nv_bits_o(nv_bits_o), .status_o(status_o));
  spi_master_model u_m (.so_i(so_w), .sck_o(sck_i), .cs_b_o(cs_b_i), .si_o(si_i));
  function automatic logic [7:0] st_exp(input logic [2:0] v, input logic l);
    return {v[2], RFU_IDLE, v[1:0], l, 1'b0};
  endfunction : st_exp
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic send(input logic m3, input logic [15:0] tx, input int nb);
    u_m.frame(m3, {tx, 24'h000000}, nb, rx);
  endtask : send
  task automatic pins(input logic h, input logic w);
    @(posedge clk_i);
    #5 hold_b_i = h;
    wp_b_i = w;
  endtask : pins
  task automatic status_write_cmd(input logic [7:0] d, input logic ok);
    send(r[5], {OPC_WRITE_ENABLE, 8'h00}, 1);
    send(r[6], {OPC_STATUS_WRITE, d}, 2);
    chk("busy", {7'h0, ok}, {7'h0, status_o[0]});
    if (ok) chk("nv_bits", {5'h0, d[7], d[3:2]}, {5'h0, nv_bits_o});
    send(r[7], {OPC_WRITE_DISABLE, 8'h00}, 1);
    chk("latch", {7'h0, ok}, {7'h0, status_o[1]});
    for (int k = 0; k < 100 && status_o[0] !== 1'b0; k++) begin
      @(posedge clk_i);
      #5;
    end
    if (ok) nv = {d[7], d[3:2]};
    chk("status", st_exp(nv, 1'b0), status_o);
  endtask : status_write_cmd
  task automatic final_report();
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    mismatches++;
    final_report();
  end
  initial begin
    seed = 32'hc935ef32;
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    hold_b_i = 1'b1;
    wp_b_i = 1'b1;
    nv_init_i = 3'($random(seed));
    nv = nv_init_i;
    r = $random(seed);
    repeat (10) @(posedge clk_i);
    #5 rst_b_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #5 chk("status", st_exp(nv, 1'b0), status_o);
    status_write_cmd(r[15:8], 1'b1);
    status_write_cmd(8'h8C, 1'b1);
    send(r[5], {OPC_WRITE_ENABLE, 8'h00}, 1);
    pins(1'b1, 1'b1);
    fork
      send(r[6], {OPC_STATUS_WRITE, 8'h00}, 2);
      begin
        #200 wp_b_i = 1'b0;
        #200 wp_b_i = 1'b1;
      end
    join
    chk("busy", 8'h00, {7'h0, status_o[0]});
    chk("status", st_exp(nv, 1'b1), status_o);
    pins(1'b1, 1'b0);
    status_write_cmd(8'h00, 1'b0);
    pins(1'b1, 1'b1);
    status_write_cmd(8'h00, 1'b1);
    pins(1'b1, 1'b0);
    status_write_cmd(8'h04, 1'b1);
    pins(1'b1, 1'b1);
    send(1'b0, {OPC_STATUS_WRITE, 8'h8C}, 2);
    chk("status", st_exp(nv, 1'b0), status_o);
    send(1'b0, {OPC_WRITE_ENABLE, 8'h00}, 1);
    pins(1'b0, 1'b1);
    send(1'b1, {OPC_STATUS_READ, 8'h00}, 2);
    chk("status", st_exp(nv, 1'b0), status_o);
    pins(1'b1, 1'b1);
    send(r[0], {4'hA, r[3:0], OPC_WRITE_ENABLE}, 2);
    chk("status", st_exp(nv, 1'b0), status_o);
    u_m.cs_pulse();
    send(r[1], {OPC_STATUS_READ, 8'h00}, 2);
    chk("read", st_exp(nv, 1'b0), rx);
    u_m.frame(r[2], {OPC_ARRAY_READ, r[31:8], 8'h00}, 5, rx);
    chk("array", 8'hFF, rx);
    u_m.frame(r[3], {OPC_ARRAY_WRITE, r[23:0], r[31:24]}, 5, rx);
    chk("status", st_exp(nv, 1'b0), status_o);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      send(r[0], {(r[1] ? OPC_WRITE_ENABLE : OPC_WRITE_DISABLE) | {4'h0, r[2], 3'h0}, 8'h00}, 1);
      send(r[3], {OPC_STATUS_READ | {4'h0, r[4], 3'h0}, 8'h00}, 2);
      chk("read", st_exp(nv, r[1]), rx);
    end
    final_report();
  end
endmodule : tb_serial_eeprom_spi_front_end
bind eeprom_spi_front eeprom_spi_front_checker #(.WRITE_CYC(WRITE_CYC)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .sck_i(sck_i), .cs_b_i(cs_b_i), .si_i(si_i),
  .so_o(so_o), .so_oe_o(so_oe_o), .hold_b_i(hold_b_i), .wp_b_i(wp_b_i),
  .nv_init_i(nv_init_i), .nv_wr_o(nv_wr_o), .nv_bits_o(nv_bits_o), .status_o(status_o));
